/* File: verilog/spim_params.svh */
`ifndef SPIM_PARAMS_SVH
`define SPIM_PARAMS_SVH
`define SPIM_OFS_CTRL1 3'h0
`define SPIM_OFS_CTRL2 3'h1
`define SPIM_OFS_RATE 3'h2
`define SPIM_OFS_STATUS 3'h3
`define SPIM_OFS_DATA 3'h4
`define SPIM_C1_ENABLE 6
`define SPIM_C1_MASTER 4
`define SPIM_C1_CPOL 3
`define SPIM_C1_CPHA 2
`define SPIM_C1_SELECT_OUTPUT_ENABLE 1
`define SPIM_C1_LSBFE 0
`define SPIM_C2_FAULT_EN 4
`define SPIM_C2_DRIVE_EN 3
`define SPIM_C2_SW_SEL 0
`define SPIM_RATE_PRE_LO 4
`define SPIM_RATE_SEL_LO 0
`define SPIM_ST_RX_FULL 7
`define SPIM_ST_TX_EMPTY 5
`define SPIM_ST_FAULT 4
`define SPIM_C1_RST 8'h04
`define SPIM_C2_RST 8'h00
`define SPIM_RATE_RST 8'h00
`define SPIM_C2_MASK 8'h1B
`define SPIM_RATE_MASK 8'h77
`define SPIM_LAST_EDGE 5'h10
`endif

/* File: verilog/spim_pkg.sv */
package spim_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_XFER
    } spim_phase_t;

    typedef enum logic [1:0] {
        STOP_NONE,
        STOP_LIGHT,
        STOP_DEEP,
        STOP_DEEPEST
    } spim_stop_t;

    typedef struct packed {
        logic o;
        logic oe;
    } spim_pin_t;

    typedef struct packed {
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] rate;
        logic [7:0] tx_buf;
        logic [7:0] rx_buf;
        logic [7:0] rd_byte;
        logic tx_empty;
        logic rx_full;
        logic fault;
        spim_phase_t phase;
        logic [7:0] shreg;
        logic samp;
        logic [4:0] edge_cnt;
        logic [10:0] div_cnt;
        logic sck;
        logic [2:0] sclk_s;
        logic [2:0] mosi_s;
        logic [2:0] miso_s;
        logic [2:0] ss_s;
        logic sclk_f;
        logic sclk_q;
        logic mosi_f;
        logic miso_f;
        logic ss_f;
    } spim_state_t;
endpackage

/* File: verilog/spim_core.sv */
// Functional notes
// R1 - master starts every transfer; slave follows clock
// R2 - shift out and in together, swapping bytes
// R3 - slave takes part only while select low
// R4 - written byte waits, loads shifter at start
// R5 - received byte moves to separate read buffer
// R6 - master drives clock and MOSI, samples MISO
// R7 - slave clocked by pin, drives MISO, reads MOSI
// R8 - prescale divisor is field value plus one
// R9 - then divide by two to rate plus one
// R10 - disabled module releases all four pins
// R11 - master single-wire uses MOSI, drive enable steers
// R12 - slave single-wire uses MISO, drive enable steers
// R13 - single-wire releases the unused data pin
// R14 - master without fault detect ignores select
// R15 - fault detect: mode-fault input or auto select
// R16 - inactive in stop; deep stops return reset
// R17 - light stop halts clocks, keeps all state
// R18 - light stop exit: reset clears, interrupt resumes
// R19 - five eight-bit software registers
// R20 - disable aborts, clears receive full, sets empty
// R21 - eight clock cycles per byte, divider master-only
`include "spim_params.svh"

module spim_core (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire spim_pkg::spim_stop_t stop_mode,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wr_byte,
    output logic [7:0] reg_rd_byte,
    output logic transmit_empty_flag,
    output logic receive_full_flag,
    output logic mode_fault_flag,
    input wire logic serial_clock_pin_i,
    output spim_pkg::spim_pin_t serial_clock_pin,
    input wire logic mosi_i,
    output spim_pkg::spim_pin_t mosi,
    input wire logic miso_i,
    output spim_pkg::spim_pin_t miso,
    input wire logic ss_n_i,
    output spim_pkg::spim_pin_t ss_n
);
    spim_pkg::spim_state_t q_r;
    spim_pkg::spim_state_t q_nxt;
    logic en_w;
    logic master_w;
    logic sw_w;
    logic drv_w;
    logic act_w;
    logic dout_w;
    logic din_w;
    logic tick_w;
    logic edge_w;
    logic done_w;
    logic fault_w;
    logic [10:0] half_w;

    function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
        out_bit = lsb ? sh[0] : sh[7];
    endfunction

    function automatic logic [7:0] shift_in(
        input logic [7:0] sh,
        input logic lsb,
        input logic b
    );
        shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction

    // change accepted once second and third stage agree
    function automatic logic filt(input logic [2:0] s, input logic f);
        filt = (s[1] == s[2]) ? s[2] : f;
    endfunction

    function automatic spim_pkg::spim_state_t reset_state();
        reset_state = '0;
        reset_state.ctrl1 = `SPIM_C1_RST;
        reset_state.ctrl2 = `SPIM_C2_RST;
        reset_state.rate = `SPIM_RATE_RST;
        reset_state.tx_empty = 1'b1;
        reset_state.phase = spim_pkg::ST_IDLE;
        reset_state.sck = reset_state.ctrl1[`SPIM_C1_CPOL];
        reset_state.ss_s = 3'h7;
        reset_state.ss_f = 1'b1;
    endfunction

    assign en_w = q_r.ctrl1[`SPIM_C1_ENABLE];
    assign master_w = q_r.ctrl1[`SPIM_C1_MASTER];
    assign sw_w = q_r.ctrl2[`SPIM_C2_SW_SEL];
    assign drv_w = q_r.ctrl2[`SPIM_C2_DRIVE_EN];
    assign act_w = en_w && (stop_mode == spim_pkg::STOP_NONE); // R10 R16
    assign dout_w = out_bit(q_r.shreg, q_r.ctrl1[`SPIM_C1_LSBFE]);
    // shifter input routing per role and wire count
    assign din_w = master_w ? (sw_w ? q_r.mosi_f : q_r.miso_f) // R6 R11
                            : (sw_w ? q_r.miso_f : q_r.mosi_f); // R7 R12
    assign fault_w = en_w && master_w && q_r.ctrl2[`SPIM_C2_FAULT_EN]
                     && !q_r.ctrl1[`SPIM_C1_SELECT_OUTPUT_ENABLE] && !q_r.ss_f; // R15

    always_comb begin
        q_nxt = q_r;
        tick_w = 1'b0;
        edge_w = 1'b0;
        done_w = 1'b0;
        half_w = 11'(({8'h00, q_r.rate[`SPIM_RATE_PRE_LO +: 3]} + 11'h001)
                 << q_r.rate[`SPIM_RATE_SEL_LO +: 3]); // R8 R9
        // pin synchronisers
        q_nxt.sclk_s = {q_r.sclk_s[1:0], serial_clock_pin_i};
        q_nxt.mosi_s = {q_r.mosi_s[1:0], mosi_i};
        q_nxt.miso_s = {q_r.miso_s[1:0], miso_i};
        q_nxt.ss_s = {q_r.ss_s[1:0], ss_n_i};
        q_nxt.sclk_f = filt(q_r.sclk_s, q_r.sclk_f);
        q_nxt.mosi_f = filt(q_r.mosi_s, q_r.mosi_f);
        q_nxt.miso_f = filt(q_r.miso_s, q_r.miso_f);
        q_nxt.ss_f = filt(q_r.ss_s, q_r.ss_f);
        q_nxt.sclk_q = q_r.sclk_f;
        // software register writes
        if (reg_wr_en) begin
            case (reg_addr) // R19
                `SPIM_OFS_CTRL1: begin
                    q_nxt.ctrl1 = reg_wr_byte;
                    q_nxt.fault = 1'b0;
                end
                `SPIM_OFS_CTRL2: q_nxt.ctrl2 = reg_wr_byte & `SPIM_C2_MASK;
                `SPIM_OFS_RATE: q_nxt.rate = reg_wr_byte & `SPIM_RATE_MASK;
                `SPIM_OFS_DATA: begin
                    if (q_r.tx_empty) begin
                        q_nxt.tx_buf = reg_wr_byte; // R4
                        q_nxt.tx_empty = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // software register reads
        if (reg_rd_en) begin
            case (reg_addr) // R19
                `SPIM_OFS_CTRL1: q_nxt.rd_byte = q_r.ctrl1;
                `SPIM_OFS_CTRL2: q_nxt.rd_byte = q_r.ctrl2;
                `SPIM_OFS_RATE: q_nxt.rd_byte = q_r.rate;
                `SPIM_OFS_STATUS: begin
                    q_nxt.rd_byte = 8'h00;
                    q_nxt.rd_byte[`SPIM_ST_RX_FULL] = q_r.rx_full;
                    q_nxt.rd_byte[`SPIM_ST_TX_EMPTY] = q_r.tx_empty;
                    q_nxt.rd_byte[`SPIM_ST_FAULT] = q_r.fault;
                end
                `SPIM_OFS_DATA: begin
                    q_nxt.rd_byte = q_r.rx_buf; // R5
                    q_nxt.rx_full = 1'b0;
                end
                default: q_nxt.rd_byte = 8'h00;
            endcase
        end
        // bit-rate divider, run only by a master mid-transfer
        q_nxt.div_cnt = 11'h000;
        if (master_w && q_r.phase == spim_pkg::ST_XFER) begin // R21
            if (q_r.div_cnt == half_w - 11'h001) begin
                tick_w = 1'b1;
            end else begin
                q_nxt.div_cnt = q_r.div_cnt + 11'h001;
            end
        end
        // edge source: own tick or synchronised pin clock
        edge_w = master_w ? tick_w // R6
                          : (q_r.sclk_f != q_r.sclk_q); // R7
        case (q_r.phase)
            spim_pkg::ST_IDLE: begin
                q_nxt.edge_cnt = 5'h00;
                q_nxt.sck = q_r.ctrl1[`SPIM_C1_CPOL];
                if (master_w && !q_r.tx_empty) begin
                    q_nxt.shreg = q_r.tx_buf; // R1 R4
                    q_nxt.tx_empty = 1'b1;
                    q_nxt.phase = spim_pkg::ST_XFER;
                end else if (!master_w && !q_r.ss_f) begin
                    if (!q_r.tx_empty) begin
                        q_nxt.shreg = q_r.tx_buf; // R4
                        q_nxt.tx_empty = 1'b1;
                    end
                    q_nxt.phase = spim_pkg::ST_XFER; // R3
                end
            end
            spim_pkg::ST_XFER: begin
                if (!master_w && q_r.ss_f) begin
                    q_nxt.phase = spim_pkg::ST_IDLE; // R3
                end else if (edge_w) begin
                    q_nxt.edge_cnt = q_r.edge_cnt + 5'h01;
                    q_nxt.sck = ~q_r.sck;
                    if (!q_r.ctrl1[`SPIM_C1_CPHA]) begin
                        if (!q_r.edge_cnt[0]) begin
                            q_nxt.samp = din_w; // R2
                        end else begin
                            q_nxt.shreg = shift_in(q_r.shreg,
                                q_r.ctrl1[`SPIM_C1_LSBFE], q_r.samp);
                        end
                    end else if (q_r.edge_cnt[0]) begin
                        if (q_nxt.edge_cnt == `SPIM_LAST_EDGE) begin
                            q_nxt.shreg = shift_in(q_r.shreg,
                                q_r.ctrl1[`SPIM_C1_LSBFE], din_w); // R2
                        end else begin
                            q_nxt.samp = din_w;
                        end
                    end else if (q_r.edge_cnt != 5'h00) begin
                        q_nxt.shreg = shift_in(q_r.shreg,
                            q_r.ctrl1[`SPIM_C1_LSBFE], q_r.samp);
                    end
                    if (q_nxt.edge_cnt == `SPIM_LAST_EDGE) begin // R21
                        done_w = 1'b1;
                        q_nxt.rx_buf = q_nxt.shreg; // R5
                        q_nxt.rx_full = 1'b1;
                        q_nxt.phase = spim_pkg::ST_IDLE;
                    end
                end
            end
            default: q_nxt.phase = spim_pkg::ST_IDLE;
        endcase
        // mode fault: abort and fall back to slave
        if (fault_w) begin // R15
            q_nxt.fault = 1'b1;
            q_nxt.ctrl1[`SPIM_C1_MASTER] = 1'b0;
            q_nxt.phase = spim_pkg::ST_IDLE;
            q_nxt.sck = q_r.ctrl1[`SPIM_C1_CPOL];
        end
        if (!en_w) begin // R20
            q_nxt.phase = spim_pkg::ST_IDLE;
            q_nxt.rx_full = 1'b0;
            q_nxt.tx_empty = 1'b1;
            q_nxt.edge_cnt = 5'h00;
            q_nxt.sck = q_r.ctrl1[`SPIM_C1_CPOL];
            done_w = 1'b0;
        end
        case (stop_mode)
            spim_pkg::STOP_NONE: ;
            spim_pkg::STOP_LIGHT: begin
                q_nxt = q_r; // R17 R18
                done_w = 1'b0;
            end
            default: begin
                q_nxt = reset_state(); // R16
                done_w = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q_r <= reset_state(); // R18
        end else begin
            q_r <= q_nxt;
        end
    end

    // pin routing
    always_comb begin
        serial_clock_pin.o = q_r.sck;
        serial_clock_pin.oe = act_w && master_w; // R6 R7
        mosi.o = dout_w;
        mosi.oe = act_w && master_w && (!sw_w || drv_w); // R6 R11 R13
        miso.o = dout_w;
        miso.oe = act_w && !master_w && !q_r.ss_f
                  && (!sw_w || drv_w); // R3 R7 R12 R13
        ss_n.o = (q_r.phase != spim_pkg::ST_XFER);
        ss_n.oe = act_w && master_w && q_r.ctrl2[`SPIM_C2_FAULT_EN]
                  && q_r.ctrl1[`SPIM_C1_SELECT_OUTPUT_ENABLE]; // R14 R15
    end

    assign reg_rd_byte = q_r.rd_byte;
    assign transmit_empty_flag = q_r.tx_empty;
    assign receive_full_flag = q_r.rx_full;
    assign mode_fault_flag = q_r.fault;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    a_disable_pins: assert property ( // R10
        !en_w |-> !serial_clock_pin.oe && !mosi.oe && !miso.oe && !ss_n.oe)
        else $error("pins driven while disabled");
    a_disable_flags: assert property ( // R20
        (!en_w && stop_mode == spim_pkg::STOP_NONE)
        |=> !q_r.rx_full && q_r.tx_empty && q_r.phase == spim_pkg::ST_IDLE)
        else $error("disable did not reset flags");
    a_slave_deselect: assert property ( // R3
        (!master_w && q_r.ss_f) |-> !miso.oe)
        else $error("slave drives data while deselected");
    a_load_tx: assert property ( // R4
        (q_r.phase == spim_pkg::ST_IDLE && master_w && en_w
         && !q_r.tx_empty && !fault_w && stop_mode == spim_pkg::STOP_NONE)
        |=> q_r.phase == spim_pkg::ST_XFER && q_r.tx_empty
            && q_r.shreg == $past(q_r.tx_buf))
        else $error("transmit buffer not loaded");
    a_done_byte: assert property ( // R21
        done_w |-> q_r.edge_cnt == 5'h0F ##1
        q_r.rx_full && q_r.phase == spim_pkg::ST_IDLE
        && q_r.rx_buf == $past(q_nxt.shreg))
        else $error("byte end not after sixteen edges");
    a_read_clear: assert property ( // R5
        (reg_rd_en && reg_addr == `SPIM_OFS_DATA && !done_w && en_w
         && stop_mode == spim_pkg::STOP_NONE)
        |=> !q_r.rx_full && reg_rd_byte == $past(q_r.rx_buf))
        else $error("data read did not clear receive flag");
    a_sck_tick: assert property ( // R9
        (master_w && q_r.phase == spim_pkg::ST_XFER && !tick_w
         && !fault_w && en_w && stop_mode == spim_pkg::STOP_NONE)
        |=> $stable(q_r.sck))
        else $error("master clock moved between ticks");
    a_light_freeze: assert property ( // R17
        stop_mode == spim_pkg::STOP_LIGHT |=> q_r == $past(q_r))
        else $error("state changed in light stop");
    a_deep_reset: assert property ( // R16
        (stop_mode == spim_pkg::STOP_DEEP
         || stop_mode == spim_pkg::STOP_DEEPEST) |=> q_r == reset_state())
        else $error("deep stop did not reset");
    a_fault_abort: assert property ( // R15
        (fault_w && stop_mode == spim_pkg::STOP_NONE)
        |=> q_r.fault && !master_w && q_r.phase == spim_pkg::ST_IDLE)
        else $error("mode fault not taken");
endmodule

/* File: verif/spim_slave_model.sv */
// external slave, mode 0, msb first
module spim_slave_model (
    input wire logic sck,
    input wire logic sel_n,
    input wire logic mosi_w,
    input wire logic [7:0] tx_byte,
    output logic miso_w,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh = 8'h00;
    int n = 0;
    initial miso_w = 1'b1;
    initial rx_byte = 8'h00;
    // loads on select, shifts only on the master clock
    always @(negedge sel_n) begin
        sh = tx_byte;
        n = 0;
        miso_w = tx_byte[7];
    end
    always @(posedge sck) if (!sel_n) begin
        sh = {sh[6:0], mosi_w};
        n++;
        if (n == 8) begin
            rx_byte = sh;
            sh = tx_byte;
            n = 0;
        end
    end
    always @(negedge sck) if (!sel_n) miso_w = sh[7];
    // released line shows the inverse of the last bit
    always @(posedge sel_n) miso_w = ~miso_w;
endmodule

/* File: verif/spim_core_test.sv */
module spim_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    spim_pkg::spim_stop_t stop_mode = spim_pkg::STOP_NONE;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wr_byte = 8'h00;
    logic [7:0] reg_rd_byte, slv_rx, v;
    logic [7:0] slv_tx = 8'h00;
    logic transmit_empty_flag, receive_full_flag, mode_fault_flag;
    spim_pkg::spim_pin_t sck_p, mosi_p, miso_p, ss_p;
    logic ss_ext_n = 1'b1;
    logic sck_w, mosi_w, miso_w, ss_w, slv_miso;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int edges = 0;
    int last_rise = 0;
    int period = 0;
    // half period must exceed the master's input synchroniser lag
    logic [7:0] rates [4] = '{8'h40, 8'h13, 8'h72, 8'h37};
    assign sck_w = sck_p.oe ? sck_p.o : 1'b0;
    assign mosi_w = mosi_p.oe ? mosi_p.o : 1'b1;
    assign miso_w = miso_p.oe ? miso_p.o : slv_miso;
    assign ss_w = ss_p.oe ? ss_p.o : ss_ext_n;
    always #5 core_clk = ~core_clk;
    spim_core u_spim_core (.core_clk(core_clk), .sys_rst(sys_rst),
        .stop_mode(stop_mode), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_byte(reg_wr_byte),
        .reg_rd_byte(reg_rd_byte), .transmit_empty_flag(transmit_empty_flag),
        .receive_full_flag(receive_full_flag),
        .mode_fault_flag(mode_fault_flag), .serial_clock_pin_i(sck_w),
        .serial_clock_pin(sck_p), .mosi_i(mosi_w), .mosi(mosi_p),
        .miso_i(miso_w), .miso(miso_p), .ss_n_i(ss_w), .ss_n(ss_p));
    spim_slave_model u_spim_slave_model (.sck(sck_w), .sel_n(ss_w),
        .mosi_w(mosi_w), .tx_byte(slv_tx), .miso_w(slv_miso),
        .rx_byte(slv_rx));
    always @(posedge sck_w) begin
        edges++;
        period = cyc - last_rise;
        last_rise = cyc;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wr_byte <= d;
        reg_wr_en <= 1'b1;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        #1 chk({8'h00, reg_rd_byte}, {8'h00, exp});
    endtask
    task automatic wait_rx;
        for (int i = 0; i < 9000 && receive_full_flag !== 1'b1; i++)
            @(posedge core_clk);
        #1 chk({15'h0, receive_full_flag}, 16'h1);
    endtask
    function automatic logic [15:0] per(input logic [7:0] r);
        return (({13'h0, r[6:4]} + 16'h1) << r[2:0]) << 1;
    endfunction
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        rchk(3'h0, 8'h04);
        rchk(3'h1, 8'h00);
        rchk(3'h2, 8'h00);
        rchk(3'h3, 8'h20);
        rchk(3'h5, 8'h00);
        chk({12'h0, sck_p.oe, mosi_p.oe, miso_p.oe, ss_p.oe}, 16'h0);
        $display("test reset done");
        wr(3'h1, 8'h10);
        wr(3'h0, 8'h52);
        for (int i = 0; i < 4; i++) begin
            slv_tx <= 8'h3C + 8'(i);
            wr(3'h2, rates[i]);
            edges = 0;
            wr(3'h4, 8'hA5 ^ 8'(i));
            wait_rx();
            rchk(3'h4, 8'h3C + 8'(i));
            chk({8'h00, slv_rx}, {8'h00, 8'hA5 ^ 8'(i)});
            chk(16'(edges), 16'h8);
            chk(16'(period), per(rates[i]));
            chk({12'h0, sck_p.oe, mosi_p.oe, miso_p.oe, ss_p.oe}, 16'hD);
        end
        $display("test rates done");
        slv_tx <= 8'h5A;
        wr(3'h2, 8'h40);
        wr(3'h4, 8'h11);
        wr(3'h4, 8'h22);
        #1 chk({15'h0, transmit_empty_flag}, 16'h0);
        wait_rx();
        rchk(3'h4, 8'h5A);
        wait_rx();
        chk({8'h00, slv_rx}, 16'h22);
        rchk(3'h4, 8'h5A);
        $display("test queue done");
        wr(3'h2, 8'h37);
        wr(3'h4, 8'hFF);
        repeat (100) @(posedge core_clk);
        wr(3'h0, 8'h12);
        rchk(3'h3, 8'h20);
        chk({12'h0, sck_p.oe, mosi_p.oe, miso_p.oe, ss_p.oe}, 16'h0);
        $display("test abort done");
        wr(3'h1, 8'h19);
        wr(3'h0, 8'h52);
        #1 chk({14'h0, mosi_p.oe, miso_p.oe}, 16'h2);
        wr(3'h1, 8'h11);
        #1 chk({14'h0, mosi_p.oe, miso_p.oe}, 16'h0);
        $display("test single wire done");
        wr(3'h1, 8'h10);
        wr(3'h0, 8'h50);
        #1 chk({15'h0, ss_p.oe}, 16'h0);
        ss_ext_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        rchk(3'h3, 8'h30);
        rchk(3'h0, 8'h40);
        ss_ext_n <= 1'b1;
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h52);
        #1 chk({15'h0, ss_p.oe}, 16'h0);
        $display("test select done");
        @(posedge core_clk);
        stop_mode <= spim_pkg::STOP_LIGHT;
        wr(3'h0, 8'h00);
        @(posedge core_clk);
        stop_mode <= spim_pkg::STOP_NONE;
        rchk(3'h0, 8'h52);
        @(posedge core_clk);
        stop_mode <= spim_pkg::STOP_DEEP;
        repeat (3) @(posedge core_clk);
        stop_mode <= spim_pkg::STOP_NONE;
        rchk(3'h0, 8'h04);
        $display("test stop done");
        end_of_test();
    end
endmodule
